// [logic/pixel_phase_pulse_generators.sv]
// Six pixel-phase pulse generators with an Avalon-MM register slave
//
// Behaviour
// - Output turns on when the edge count equals the channel's 7-bit on point.
// - Output turns off when the edge count equals the channel's 7-bit off point.
// - Any edge position within one pixel period is a valid on or off point.
// - Half-rate channels count edges across two pixel periods.
// - Six independent generators, two to seven, each with own on and off points.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps

`include "pulse_gen_cfg.svh"

module pixel_phase_pulse_generators
  import pulse_gen_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // Avalon-MM slave
  input  wire logic [7:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic [31:0] writedata_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  // Sensor timing outputs
  output logic             sensor_pulse_two_o,
  output logic             sensor_pulse_three_o,
  output logic             sensor_pulse_four_o,
  output logic             sensor_pulse_five_o,
  output logic             sensor_pulse_six_o,
  output logic             sensor_pulse_seven_o
);

  // ----------------------------------------------------------------
  // Channel tables
  // ----------------------------------------------------------------
  localparam logic [5:0][5:0] RISE_IDX =
  {
    `PG_IDX_RISE7,
    `PG_IDX_RISE6,
    `PG_IDX_RISE5,
    `PG_IDX_RISE4,
    `PG_IDX_RISE3,
    `PG_IDX_RISE2
  };
  localparam logic [5:0][5:0] FALL_IDX =
  {
    `PG_IDX_FALL7,
    `PG_IDX_FALL6,
    `PG_IDX_FALL5,
    `PG_IDX_FALL4,
    `PG_IDX_FALL3,
    `PG_IDX_FALL2
  };
  localparam logic [5:0][6:0] RISE_RST =
  {
    `PG_RST_RISE7,
    `PG_RST_RISE6,
    `PG_RST_RISE5,
    `PG_RST_RISE4,
    `PG_RST_RISE3,
    `PG_RST_RISE2
  };
  localparam logic [5:0][6:0] FALL_RST =
  {
    `PG_RST_FALL7,
    `PG_RST_FALL6,
    `PG_RST_FALL5,
    `PG_RST_FALL4,
    `PG_RST_FALL3,
    `PG_RST_FALL2
  };

  pg_state_t   s_q;
  pg_state_t   s_d;

  logic [5:0]  idx;
  logic        req;
  logic        wr_go;
  logic        wr_lo;
  logic [5:0]  wr_rise;
  logic [5:0]  wr_fall;
  logic [5:0]  on_hit;
  logic [5:0]  off_hit;
  logic [5:0]  pulse_nx;
  logic [5:0]  sel_rise;
  logic [5:0]  sel_fall;
  logic        fc_wrap;
  logic        hc_wrap;
  logic [31:0] rd_mux;
  logic [6:0]  wd_pt;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Registers sit one per word; low address bits ignored
  assign idx   = address_i[7:2];
  assign req   = read_i | write_i;
  // Write lands at the edge where waitrequest is seen low
  assign wr_go = write_i & s_q.ack & ce_i;
  assign wr_lo = wr_go & byteenable_i[0];
  assign wd_pt = writedata_i[6:0];

  // Held high while frozen, so a write is never dropped
  assign waitrequest_o = req & ~(s_q.ack & ce_i);
  assign readdata_o    = s_q.rdata;

  // ----------------------------------------------------------------
  // Edge position counters
  // ----------------------------------------------------------------
  assign fc_wrap = s_q.fc == s_q.last;
  assign hc_wrap = fc_wrap & s_q.phase;

  // ----------------------------------------------------------------
  // Per-channel compare and register select
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PG_NUM_CH; g++)
    begin : g_ch
      logic [7:0] pos;
      // Half-rate channels see the doubled span
      assign pos = s_q.half[g] ? s_q.hc : {1'b0, s_q.fc};
      assign on_hit[g]  = s_q.run & (pos == {1'b0, s_q.rise[g]});
      assign off_hit[g] = s_q.run & (pos == {1'b0, s_q.fall[g]});
      // Off wins on a tie so equal points give no pulse
      assign pulse_nx[g] = s_q.run & ~off_hit[g] &
                           (on_hit[g] | s_q.pulse[g]);
      assign sel_rise[g] = idx == RISE_IDX[g];
      assign sel_fall[g] = idx == FALL_IDX[g];
      assign wr_rise[g]  = wr_lo & sel_rise[g];
      assign wr_fall[g]  = wr_lo & sel_fall[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < `PG_NUM_CH; i++)
    begin
      // Reserved top bit reads zero
      if (sel_rise[i])
      begin
        rd_mux = {25'h000_0000, s_q.rise[i]};
      end
      if (sel_fall[i])
      begin
        rd_mux = {25'h000_0000, s_q.fall[i]};
      end
    end
    if (idx == `PG_IDX_CTRL)
    begin
      rd_mux[`PG_CTRL_LAST_LSB +: 7] = s_q.last;
      rd_mux[`PG_CTRL_RUN_BIT]       = s_q.run;
    end
    if (idx == `PG_IDX_HALF)
    begin
      rd_mux[5:0] = s_q.half;
    end
    if (idx == `PG_IDX_STATUS)
    begin
      rd_mux[`PG_STAT_CNT_LSB +: 7] = s_q.fc;
      rd_mux[`PG_STAT_OUT_LSB +: 6] = s_q.pulse;
      rd_mux[`PG_STAT_PH_BIT]       = s_q.phase;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // Bus handshake: one wait cycle, then the answer
    s_d.ack = req & ~s_q.ack;
    if (req & ~s_q.ack)
    begin
      s_d.rdata = rd_mux;
    end
    for (int i = 0; i < `PG_NUM_CH; i++)
    begin
      // Top bit dropped so a stray one has no effect
      if (wr_rise[i])
      begin
        s_d.rise[i] = writedata_i[6:0];
      end
      if (wr_fall[i])
      begin
        s_d.fall[i] = writedata_i[6:0];
      end
    end
    if (wr_lo && idx == `PG_IDX_CTRL)
    begin
      s_d.last = writedata_i[`PG_CTRL_LAST_LSB +: 7];
    end
    if (wr_go && byteenable_i[1] && idx == `PG_IDX_CTRL)
    begin
      s_d.run = writedata_i[`PG_CTRL_RUN_BIT];
    end
    if (wr_lo && idx == `PG_IDX_HALF)
    begin
      s_d.half = writedata_i[5:0];
    end
    // Counters restart at zero while stopped
    if (!s_q.run)
    begin
      s_d.fc    = 7'h00;
      s_d.hc    = 8'h00;
      s_d.phase = 1'b0;
    end
    else if (fc_wrap)
    begin
      s_d.fc    = 7'h00;
      s_d.phase = ~s_q.phase;
      s_d.hc    = hc_wrap ? 8'h00 : s_q.hc + 8'h01;
    end
    else
    begin
      s_d.fc = s_q.fc + 7'h01;
      s_d.hc = s_q.hc + 8'h01;
    end
    s_d.pulse = pulse_nx;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_q.rise  <= RISE_RST;
      s_q.fall  <= FALL_RST;
      s_q.last  <= `PG_RST_LAST;
      s_q.run   <= `PG_RST_RUN;
      s_q.half  <= `PG_RST_HALF;
      s_q.fc    <= 7'h00;
      s_q.hc    <= 8'h00;
      s_q.phase <= 1'b0;
      s_q.pulse <= 6'h00;
      s_q.ack   <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      s_q <= s_d;
    end
  end

  assign sensor_pulse_two_o   = s_q.pulse[0];
  assign sensor_pulse_three_o = s_q.pulse[1];
  assign sensor_pulse_four_o  = s_q.pulse[2];
  assign sensor_pulse_five_o  = s_q.pulse[3];
  assign sensor_pulse_six_o   = s_q.pulse[4];
  assign sensor_pulse_seven_o = s_q.pulse[5];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < `PG_NUM_CH; g++)
    begin : g_chk
      property p_turn_on;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && on_hit[g] && !off_hit[g] |=> s_q.pulse[g];
      endproperty
      a_turn_on: assert property (p_turn_on)
        else $error("pulse did not turn on at on point");

      property p_turn_off;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && s_q.pulse[g] && off_hit[g] |=> !s_q.pulse[g];
      endproperty
      a_turn_off: assert property (p_turn_off)
        else $error("pulse did not turn off at off point");

      property p_no_stray;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && !s_q.pulse[g] && !on_hit[g] |=> !s_q.pulse[g];
      endproperty
      a_no_stray: assert property (p_no_stray)
        else $error("pulse rose without an on point match");

      property p_own_regs;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && wr_lo && !sel_rise[g] && !sel_fall[g]
        |=> $stable(s_q.rise[g]) && $stable(s_q.fall[g]);
      endproperty
      a_own_regs: assert property (p_own_regs)
        else $error("write disturbed another channel");

      property p_hold_on;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && s_q.run && s_q.pulse[g] && !off_hit[g] |=> s_q.pulse[g];
      endproperty
      a_hold_on: assert property (p_hold_on)
        else $error("pulse dropped before its off point");

      property p_rise_write;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && wr_rise[g] |=> s_q.rise[g] == $past(wd_pt);
      endproperty
      a_rise_write: assert property (p_rise_write)
        else $error("on point write did not land");

      property p_fall_write;
        @(posedge clk_i) disable iff (reset_i)
        ce_i && wr_fall[g] |=> s_q.fall[g] == $past(wd_pt);
      endproperty
      a_fall_write: assert property (p_fall_write)
        else $error("off point write did not land");
    end
  endgenerate

  property p_full_span;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && s_q.run && fc_wrap && !wr_go |=> s_q.fc == 7'h00;
  endproperty
  a_full_span: assert property (p_full_span)
    else $error("edge counter did not wrap at period end");

  property p_double_span;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && s_q.run && fc_wrap && !s_q.phase && !wr_go
    |=> s_q.phase && s_q.hc == {1'b0, s_q.last} + 8'h01;
  endproperty
  a_double_span: assert property (p_double_span)
    else $error("half rate count did not continue into second period");

  property p_half_wrap;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && s_q.run && hc_wrap && !wr_go |=> s_q.hc == 8'h00 && !s_q.phase;
  endproperty
  a_half_wrap: assert property (p_half_wrap)
    else $error("half rate count did not wrap after two periods");

  property p_stopped_quiet;
    @(posedge clk_i) disable iff (reset_i)
    ce_i && !s_q.run |=> s_q.pulse == 6'h00;
  endproperty
  a_stopped_quiet: assert property (p_stopped_quiet)
    else $error("pulse output active while counters stopped");

endmodule

// [pkg/pulse_gen_cfg.svh]
// Offsets, field positions, reset values and sizes for the pulse generators
`ifndef PULSE_GEN_CFG_SVH
`define PULSE_GEN_CFG_SVH

`define PG_NUM_CH        6
`define PG_PT_W          7
`define PG_HC_W          8

`define PG_IDX_RISE2     6'h0a
`define PG_IDX_FALL2     6'h0b
`define PG_IDX_RISE3     6'h0d
`define PG_IDX_FALL3     6'h0e
`define PG_IDX_RISE4     6'h10
`define PG_IDX_FALL4     6'h11
`define PG_IDX_RISE5     6'h13
`define PG_IDX_FALL5     6'h14
`define PG_IDX_RISE6     6'h16
`define PG_IDX_FALL6     6'h17
`define PG_IDX_RISE7     6'h19
`define PG_IDX_FALL7     6'h1a
`define PG_IDX_CTRL      6'h20
`define PG_IDX_HALF      6'h21
`define PG_IDX_STATUS    6'h22

`define PG_RST_RISE2     7'h00
`define PG_RST_FALL2     7'h15
`define PG_RST_RISE3     7'h0b
`define PG_RST_FALL3     7'h0d
`define PG_RST_RISE4     7'h10
`define PG_RST_FALL4     7'h13
`define PG_RST_RISE5     7'h00
`define PG_RST_FALL5     7'h00
`define PG_RST_RISE6     7'h00
`define PG_RST_FALL6     7'h00
`define PG_RST_RISE7     7'h00
`define PG_RST_FALL7     7'h00
`define PG_RST_LAST      7'h2f
`define PG_RST_RUN       1'b0
`define PG_RST_HALF      6'h00

`define PG_CTRL_LAST_LSB 0
`define PG_CTRL_RUN_BIT  8
`define PG_STAT_CNT_LSB  0
`define PG_STAT_OUT_LSB  8
`define PG_STAT_PH_BIT   16

`endif

// [pkg/pulse_gen_pkg.sv]
// Types shared by the pulse generator block
package pulse_gen_pkg;

  typedef logic [6:0] point_t;

  typedef struct packed {
    logic [5:0][6:0] rise;
    logic [5:0][6:0] fall;
    logic [6:0]      last;
    logic            run;
    logic [5:0]      half;
    logic [6:0]      fc;
    logic [7:0]      hc;
    logic            phase;
    logic [5:0]      pulse;
    logic            ack;
    logic [31:0]     rdata;
  } pg_state_t;

endpackage

// [bench/sensor_model.sv]
// Sensor side model: counts high cycles on each timing input
`timescale 1ns/1ps

module sensor_model
(
  // Clock and clear
  input  wire logic            clk_i,
  input  wire logic            clr_i,
  // Timing inputs, bit 0 is channel two
  input  wire logic [5:0]      pulse_i,
  // High cycle counts per channel
  output logic      [5:0][7:0] cnt_o
);
  // Level sampled each edge; one edge equals one edge position
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (clr_i)
        cnt_o[i] <= 8'h00;
      else
        cnt_o[i] <= cnt_o[i] + 8'(pulse_i[i]);
    end
  end
endmodule

// [bench/test_pixel_phase_pulse_generators.sv]
// Register and pulse timing bench for the pulse generators
`timescale 1ns/1ps

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch %0t got %h exp %h", $time, (a), (b)); end end

module test_pixel_phase_pulse_generators;
  import pulse_gen_pkg::*;

  logic            clk_i = 0;
  logic            reset_i = 1;
  logic [7:0]      address_i = 8'h00;
  logic            read_i = 0;
  logic            write_i = 0;
  logic [31:0]     writedata_i = 32'h0000_0000;
  logic [31:0]     readdata_o;
  logic            waitrequest_o;
  logic [5:0]      pulse;
  logic            clr = 0;
  logic [5:0][7:0] cnt;
  logic [31:0]     rd;
  int              n_errors = 0;
  int              n_tests = 0;

  // Rise then fall per channel, two to seven
  localparam logic [7:0] OFS [12] = '{8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h10, 8'h11,
                                      8'h13, 8'h14, 8'h16, 8'h17, 8'h19, 8'h1a};
  localparam logic [6:0] RST [12] = '{7'h00, 7'h15, 7'h0b, 7'h0d, 7'h10, 7'h13,
                                      7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
  // Period 8; channels six and seven half rate, span 16
  localparam logic [6:0] RISE [6] = '{7'h01, 7'h06, 7'h00, 7'h04, 7'h02, 7'h0e};
  localparam logic [6:0] FALL [6] = '{7'h03, 7'h02, 7'h07, 7'h04, 7'h0d, 7'h01};
  // High cycles in 32 clocks
  localparam logic [7:0] EXP [6] = '{8'h08, 8'h10, 8'h1c, 8'h00, 8'h16, 8'h06};

  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  pixel_phase_pulse_generators i_pixel_phase_pulse_generators (
    .clk_i                (clk_i),
    .reset_i              (reset_i),
    .ce_i                 (1'b1),
    .address_i            (address_i),
    .read_i               (read_i),
    .write_i              (write_i),
    .byteenable_i         (4'hf),
    .writedata_i          (writedata_i),
    .readdata_o           (readdata_o),
    .waitrequest_o        (waitrequest_o),
    .sensor_pulse_two_o   (pulse[0]),
    .sensor_pulse_three_o (pulse[1]),
    .sensor_pulse_four_o  (pulse[2]),
    .sensor_pulse_five_o  (pulse[3]),
    .sensor_pulse_six_o   (pulse[4]),
    .sensor_pulse_seven_o (pulse[5])
  );

  sensor_model i_sensor_model (
    .clk_i   (clk_i),
    .clr_i   (clr),
    .pulse_i (pulse),
    .cnt_o   (cnt)
  );

  task automatic test_done;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One bus cycle; held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    @(posedge clk_i);
    address_i   <= {idx[5:0], 2'b00};
    writedata_i <= wd;
    write_i     <= we;
    read_i      <= ~we;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk_i);
      if (waitrequest_o === 1'b0)
        break;
    end
    if (k == 50)
    begin
      n_errors++;
      test_done();
    end
    // Answer taken at the edge that saw waitrequest low, then released
    rd = readdata_o;
    write_i <= 1'b0;
    read_i  <= 1'b0;
  endtask

  // Count over four full periods, two half-rate spans
  task automatic measure;
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (32) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    test_done();
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      xfer(1'b0, OFS[i], 32'h0000_0000);
      `CHK(rd, 32'(RST[i]))
    end
    xfer(1'b0, 8'h20, 32'h0000_0000);
    `CHK(rd, 32'h0000_002f)
    xfer(1'b0, 8'h3f, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    // Highest point reachable; reserved bit kept zero
    xfer(1'b1, OFS[0], 32'h0000_007f);
    xfer(1'b0, OFS[0], 32'h0000_0000);
    `CHK(rd, 32'h0000_007f)
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b1, OFS[2 * i], 32'(RISE[i]));
      xfer(1'b1, OFS[2 * i + 1], 32'(FALL[i]));
    end
    xfer(1'b1, 8'h21, 32'h0000_0030);
    // Not yet running: every output idle
    measure();
    `CHK(cnt, 48'h0000_0000_0000)
    xfer(1'b1, 8'h20, 32'h0000_0107);
    repeat (40) @(posedge clk_i);
    measure();
    for (int i = 0; i < 4; i++)
      `CHK(cnt[i], EXP[i])
    for (int i = 4; i < 6; i++)
      `CHK(cnt[i], EXP[i])
    xfer(1'b0, 8'h20, 32'h0000_0000);
    `CHK(rd, 32'h0000_0107)
    xfer(1'b0, 8'h21, 32'h0000_0000);
    `CHK(rd, 32'h0000_0030)
    // Stopped: counters cleared and every output idle
    xfer(1'b1, 8'h20, 32'h0000_0007);
    xfer(1'b0, 8'h22, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    measure();
    `CHK(cnt, 48'h0000_0000_0000)
    test_done();
  end
endmodule
